// File: rtl/dpm_pkg.sv
// dpm_pkg: constants shared by the dual-port mailbox ram port controller
package dpm_pkg;
  localparam int          ADDR_W         = 11;
  localparam int          DATA_W         = 8;
  localparam logic [10:0] MBOX_OWN_ADDR  = 11'h7fe;  // left port mailbox, cleared by left read
  localparam logic [10:0] MBOX_PEER_ADDR = 11'h7ff;  // right port mailbox, set by left write
  localparam int          CLK_NS         = 20;
  localparam int          SETUP_NS       = 30;       // busy settle before write pulse
  localparam int          SETUP_CYC      = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PULSE_NS       = 60;       // write pulse / read access width
  localparam int          PULSE_CYC      = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          HOLD_NS        = 20;       // write hold after strobe release
  localparam int          HOLD_CYC       = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  CNT_SETUP      = 4'(SETUP_CYC);
  localparam logic [3:0]  CNT_PULSE      = 4'(PULSE_CYC);
  localparam logic [3:0]  CNT_HOLD       = 4'(HOLD_CYC);
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_STALL, ST_HOLD} dpm_state_t;
endpackage

// File: rtl/dpm_data_pins.sv
// dpm_data_pins: registered three-state data bus driver for one ram port
`timescale 1ns/1ps
`default_nettype none
module dpm_data_pins
  import dpm_pkg::*;
#(
  parameter int W = DATA_W
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         drive_i,
  input  wire logic [W-1:0] wdata_i,
  output logic      [W-1:0] dq_o,
  output logic      [W-1:0] dq_oe_o
);
  logic [W-1:0] dq_r;
  logic [W-1:0] dq_nxt;
  logic [W-1:0] oe_r;
  logic [W-1:0] oe_nxt;

  // one enable per data bit so the bench resolves each wire alone
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        dq_nxt[g] = drive_i ? wdata_i[g] : dq_r[g];
        oe_nxt[g] = drive_i;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dq_r <= '0;
      oe_r <= '0;
    end else begin
      dq_r <= dq_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign dq_o    = dq_r;
  assign dq_oe_o = oe_r;
endmodule
`default_nettype wire

// File: rtl/dpm_port_ctrl.sv
// dpm_port_ctrl: controller driving the left port of a dual-port mailbox ram
`timescale 1ns/1ps
`default_nettype none
module dpm_port_ctrl
  import dpm_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // user command side
  input  wire logic              req_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   mail_irq_o,
  output logic                   contention_err_o,
  // ram port pins
  output logic [ADDR_W-1:0]      ram_addr_o,
  output logic                   ram_ce_n_o,
  output logic                   ram_rw_n_o,
  output logic                   ram_oe_n_o,
  output logic [DATA_W-1:0]      ram_dq_o,
  output logic [DATA_W-1:0]      ram_dq_oe_o,
  input  wire logic [DATA_W-1:0] ram_dq_i,
  input  wire logic              left_contention_n_i,
  input  wire logic              left_mail_flag_n_i
);
  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  dpm_state_t        st_r, st_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdat_r, wdat_nxt;
  logic [DATA_W-1:0] rdat_r, rdat_nxt;
  logic              wr_r, wr_nxt;
  logic              ce_n_r, ce_n_nxt;
  logic              rw_n_r, rw_n_nxt;
  logic              oe_n_r, oe_n_nxt;
  logic              rdy_r, rdy_nxt;
  logic              done_r, done_nxt;
  logic              drive;
  logic              busy_seen;

  // sampled busy; pins are synchronous to sys_clk by contract
  assign busy_seen = !left_contention_n_i;       // one shared line; tied high it never stalls

  // next-state logic for the access cycle
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rdat_nxt = rdat_r;
    wr_nxt   = wr_r;
    ce_n_nxt = ce_n_r;
    rw_n_nxt = rw_n_r;
    oe_n_nxt = oe_n_r;
    rdy_nxt  = rdy_r;
    done_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (req_i && rdy_r) begin
          addr_nxt = req_addr_i;                 // mailboxes are plain bytes here
          wdat_nxt = req_wdata_i;
          wr_nxt   = req_write_i;
          ce_n_nxt = 1'b0;                       // address and enable first
          rdy_nxt  = 1'b0;
          cnt_nxt  = CNT_SETUP;
          st_nxt   = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_r > 4'h1) begin
          cnt_nxt = cnt_r - 4'h1;
        end else if (busy_seen) begin
          st_nxt = ST_STALL;                     // wait out the other side
        end else begin
          rw_n_nxt = !wr_r;
          oe_n_nxt = wr_r;                       // read drives oe low
          cnt_nxt  = CNT_PULSE;
          st_nxt   = ST_PULSE;
        end
      end
      ST_STALL: begin
        // a write started under busy would be dropped inside the ram
        if (!busy_seen) begin
          cnt_nxt = CNT_SETUP;
          st_nxt  = ST_SETUP;
        end
      end
      ST_PULSE: begin
        if (busy_seen) begin
          // busy during the pulse: write void, read data unreliable
          rw_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          st_nxt   = ST_STALL;
        end else if (cnt_r > 4'h1) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          if (!wr_r) begin
            rdat_nxt = ram_dq_i;
          end
          rw_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          cnt_nxt  = CNT_HOLD;
          st_nxt   = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt_r > 4'h1) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          ce_n_nxt = 1'b1;                       // deselect: port powers down
          rdy_nxt  = 1'b1;
          done_nxt = 1'b1;
          st_nxt   = ST_IDLE;
        end
      end
      default: begin
        st_nxt   = ST_IDLE;
        ce_n_nxt = 1'b1;
        rw_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        rdy_nxt  = 1'b1;
      end
    endcase
  end

  // registers of the access cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r   <= ST_IDLE;
      cnt_r  <= 4'h0;
      addr_r <= '0;
      wdat_r <= '0;
      rdat_r <= '0;
      wr_r   <= 1'b0;
      ce_n_r <= 1'b1;
      rw_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      rdy_r  <= 1'b1;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rdat_r <= rdat_nxt;
      wr_r   <= wr_nxt;
      ce_n_r <= ce_n_nxt;
      rw_n_r <= rw_n_nxt;
      oe_n_r <= oe_n_nxt;
      rdy_r  <= rdy_nxt;
      done_r <= done_nxt;
    end
  end

  // ---------------------------------------------------------------
  // status flags seen by the user
  // ---------------------------------------------------------------
  logic irq_r, irq_nxt;
  logic err_r, err_nxt;

  // the flag is a level from the ram; err is sticky until next request
  always_comb begin
    irq_nxt = !left_mail_flag_n_i;
    err_nxt = err_r;
    if (req_i && rdy_r) begin
      err_nxt = 1'b0;
    end
    if (busy_seen && !ce_n_r) begin
      err_nxt = 1'b1;                            // set wins over clear
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
      err_r <= err_nxt;
    end
  end

  // ---------------------------------------------------------------
  // data pins and outputs
  // ---------------------------------------------------------------
  // data driven only in the cycle the write strobe is active next
  assign drive = (st_nxt == ST_PULSE) && wr_r && (st_r == ST_SETUP || st_r == ST_PULSE);

  dpm_data_pins #(.W(DATA_W)) u_dq (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .drive_i   (drive),
    .wdata_i   (wdat_r),
    .dq_o      (ram_dq_o),
    .dq_oe_o   (ram_dq_oe_o)
  );

  assign req_ready_o      = rdy_r;
  assign done_o           = done_r;
  assign rdata_o          = rdat_r;
  assign mail_irq_o       = irq_r;
  assign contention_err_o = err_r;
  assign ram_addr_o       = addr_r;
  assign ram_ce_n_o       = ce_n_r;
  assign ram_rw_n_o       = rw_n_r;
  assign ram_oe_n_o       = oe_n_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_wr_start;
    $fell(ram_rw_n_o);
  endsequence

  a_setup_before_wr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_wr_start |-> !ram_ce_n_o && $stable(ram_addr_o) && !$past(ram_ce_n_o))
    else $error("write strobe without settled address and enable");
  a_no_oe_on_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !ram_rw_n_o |-> ram_oe_n_o)
    else $error("output enable low during write");
  a_strobe_needs_ce: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!ram_rw_n_o || !ram_oe_n_o) |-> !ram_ce_n_o)
    else $error("strobe active while port deselected");
  a_data_with_strobe: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ram_dq_oe_o != '0) == !ram_rw_n_o)
    else $error("data drive not aligned with write strobe");
  a_no_drive_on_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !ram_oe_n_o |-> ram_dq_oe_o == '0)
    else $error("controller drives data while ram outputs");
  a_busy_stops_wr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!ram_rw_n_o && busy_seen) |=> ram_rw_n_o)
    else $error("write strobe kept under busy");
  a_done_ends_ce: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    done_o |-> ram_ce_n_o && req_ready_o)
    else $error("done without port release");
  a_read_captures: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ($rose(ram_oe_n_o) && st_r == ST_HOLD) |-> rdata_o == $past(ram_dq_i))
    else $error("read data not captured");
  a_err_on_busy: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (busy_seen && !ram_ce_n_o) |=> contention_err_o)
    else $error("contention not flagged");
  a_irq_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 mail_irq_o == !$past(left_mail_flag_n_i))
    else $error("mail flag not mirrored");
endmodule
`default_nettype wire

// File: test/dpm_ram_model.sv
// dpm_ram_model: behavioural dual-port mailbox ram, left port faces the dut
`timescale 1ns/1ps
`default_nettype none
module dpm_ram_model
  import dpm_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [ADDR_W-1:0] la_i,
  input  wire logic              lce_n_i,
  input  wire logic              lrw_n_i,
  input  wire logic              loe_n_i,
  input  wire logic [DATA_W-1:0] ld_i,
  input  wire logic [DATA_W-1:0] ld_oe_i,
  output logic      [DATA_W-1:0] ld_o,
  output logic                   lbusy_n_o,
  output var logic               lflag_n_o,
  input  wire logic [ADDR_W-1:0] ra_i,
  input  wire logic              rce_n_i,
  input  wire logic              rrw_n_i,
  input  wire logic              roe_n_i,
  input  wire logic [DATA_W-1:0] rd_i,
  output var logic               rflag_n_o,
  input  wire logic              hold_n_i
);
  logic [DATA_W-1:0] mem [0:2**ADDR_W-1];
  logic [DATA_W-1:0] last_r = 8'h00;
  logic [ADDR_W-1:0] la_q = '0;
  logic [ADDR_W-1:0] ra_q = '0;
  logic              lce_q = 1'b1;
  logic              rce_q = 1'b1;
  logic              match_q = 1'b0;
  logic              l_lose_q = 1'b0;
  logic              match;
  logic              l_moved;
  logic              r_moved;
  logic              l_lose;
  logic              rbusy_n;
  logic              lwr;
  logic              rwr;
  initial lflag_n_o = 1'b1;
  initial rflag_n_o = 1'b1;
  // busy from enables and address only; the port that came later loses
  assign match = !lce_n_i && !rce_n_i && la_i == ra_i;
  // a port whose address or enable moved since the last edge is the later one; a tie goes against the right
  assign l_moved = !lce_n_i && (lce_n_i != lce_q || la_i != la_q);
  assign r_moved = !rce_n_i && (rce_n_i != rce_q || ra_i != ra_q);
  assign l_lose = match_q ? l_lose_q : (l_moved && !r_moved);
  // hold_n_i stands for busy from an outside arbiter, as a slave part sees it
  assign lbusy_n_o = hold_n_i && !(match && l_lose);
  assign rbusy_n = !(match && !l_lose);
  assign lwr = !lce_n_i && !lrw_n_i && lbusy_n_o;
  assign rwr = !rce_n_i && !rrw_n_i && rbusy_n;
  // released data lines toggle so a stale byte never looks valid
  assign ld_o = (!lce_n_i && lrw_n_i && !loe_n_i) ? mem[la_i] : ~last_r;
  // array and flags, sampled at the controller clock
  always @(posedge clk_i) begin
    la_q <= la_i;
    ra_q <= ra_i;
    lce_q <= lce_n_i;
    rce_q <= rce_n_i;
    match_q <= match;
    l_lose_q <= l_lose;
    last_r <= ld_o;
    if (lwr) mem[la_i] <= ld_i & ld_oe_i;
    if (rwr) mem[ra_i] <= rd_i;
    if (lwr && la_i == MBOX_PEER_ADDR) rflag_n_o <= 1'b0;
    else if (!rce_n_i && !roe_n_i && rbusy_n && ra_i == MBOX_PEER_ADDR) rflag_n_o <= 1'b1;
    if (rwr && ra_i == MBOX_OWN_ADDR) lflag_n_o <= 1'b0;
    else if (!lce_n_i && !loe_n_i && lbusy_n_o && la_i == MBOX_OWN_ADDR) lflag_n_o <= 1'b1;
  end
endmodule
`default_nettype wire

// File: test/dual_port_mailbox_ram_tb_top.sv
// dual_port_mailbox_ram_tb_top: self-checking bench for the left port controller
`timescale 1ns/1ps
`default_nettype none
module dual_port_mailbox_ram_tb_top;
  import dpm_pkg::*;
  logic              sys_clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              req_i = 1'b0;
  logic              req_write_i = 1'b0;
  logic [ADDR_W-1:0] req_addr_i = 11'h000;
  logic [DATA_W-1:0] req_wdata_i = 8'h00;
  logic [ADDR_W-1:0] ra = 11'h000;
  logic [DATA_W-1:0] rd = 8'h00;
  logic              rce_n = 1'b1;
  logic              rrw_n = 1'b1;
  logic              roe_n = 1'b1;
  logic              hold_n = 1'b1;
  logic [ADDR_W-1:0] ram_addr_o;
  logic [DATA_W-1:0] rdata_o, ram_dq_o, ram_dq_oe_o, ram_dq_i;
  logic              req_ready_o, done_o, mail_irq_o, contention_err_o;
  logic              ram_ce_n_o, ram_rw_n_o, ram_oe_n_o, busy_n, lflag_n, rflag_n;
  int                fail_count = 0;
  int                comparisons = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  dpm_port_ctrl dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .rdata_o(rdata_o), .mail_irq_o(mail_irq_o), .contention_err_o(contention_err_o),
    .ram_addr_o(ram_addr_o), .ram_ce_n_o(ram_ce_n_o), .ram_rw_n_o(ram_rw_n_o), .ram_oe_n_o(ram_oe_n_o),
    .ram_dq_o(ram_dq_o), .ram_dq_oe_o(ram_dq_oe_o), .ram_dq_i(ram_dq_i),
    .left_contention_n_i(busy_n), .left_mail_flag_n_i(lflag_n));
  dpm_ram_model dev_u (.clk_i(sys_clk_i), .la_i(ram_addr_o), .lce_n_i(ram_ce_n_o), .lrw_n_i(ram_rw_n_o),
    .loe_n_i(ram_oe_n_o), .ld_i(ram_dq_o), .ld_oe_i(ram_dq_oe_o), .ld_o(ram_dq_i), .lbusy_n_o(busy_n),
    .lflag_n_o(lflag_n), .ra_i(ra), .rce_n_i(rce_n), .rrw_n_i(rrw_n), .roe_n_i(roe_n), .rd_i(rd),
    .rflag_n_o(rflag_n), .hold_n_i(hold_n));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // request held one edge only; the controller is idle when this is called
  task automatic start(input logic wr, input logic [10:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    req_i = 1'b1;
    req_write_i = wr;
    req_addr_i = a;
    req_wdata_i = d;
    @(negedge sys_clk_i);
    req_i = 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done_o !== 1'b1 && n < 60) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 60) begin
      fail_count++;
      stop_test();
    end
  endtask
  task automatic acc(input logic wr, input logic [10:0] a, input logic [7:0] d);
    start(wr, a, d);
    wait_done();
  endtask
  task automatic rport(input logic ce, input logic rw, input logic oe, input logic [10:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    rce_n = ce;
    rrw_n = rw;
    roe_n = oe;
    ra = a;
    rd = d;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({req_ready_o, done_o, mail_irq_o, contention_err_o, ram_ce_n_o, ram_rw_n_o, ram_oe_n_o, ram_dq_oe_o},
          {7'b1000111, 8'h00});
  endtask
  task automatic t_rw();
    logic [10:0] at [3] = '{11'h000, 11'h7fd, 11'h3a5};
    logic [7:0]  dt [3] = '{8'h5a, 8'ha5, 8'hff};
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, at[i], dt[i]);
      check(ram_addr_o, at[i]);
      check(dev_u.mem[at[i]], dt[i]);
      acc(1'b0, at[i], 8'h00);
      check(rdata_o, dt[i]);
    end
  endtask
  task automatic t_mail_out();
    acc(1'b1, 11'h7ff, 8'h3c);
    check(rflag_n, 1'b0);
    rport(1'b0, 1'b1, 1'b0, 11'h7ff, 8'h00);
    rport(1'b1, 1'b1, 1'b1, 11'h000, 8'h00);
    check(rflag_n, 1'b1);
    check(dev_u.mem[11'h7ff], 8'h3c);
  endtask
  // flag clear attempted while the far port holds the mailbox: no change
  task automatic t_mail_in();
    rport(1'b0, 1'b0, 1'b1, 11'h7fe, 8'h96);
    rport(1'b0, 1'b1, 1'b0, 11'h7fe, 8'h00);
    repeat (2) @(negedge sys_clk_i);
    check(mail_irq_o, 1'b1);
    start(1'b0, 11'h7fe, 8'h00);
    repeat (10) @(negedge sys_clk_i);
    check({mail_irq_o, contention_err_o, lflag_n}, 3'b110);
    rport(1'b1, 1'b1, 1'b1, 11'h000, 8'h00);
    wait_done();
    check(rdata_o, 8'h96);
    repeat (2) @(negedge sys_clk_i);
    check(mail_irq_o, 1'b0);
  endtask
  task automatic t_wr_block();
    acc(1'b1, 11'h123, 8'h11);
    rport(1'b0, 1'b1, 1'b0, 11'h123, 8'h00);
    start(1'b1, 11'h123, 8'h77);
    repeat (10) @(negedge sys_clk_i);
    check(dev_u.mem[11'h123], 8'h11);
    check({contention_err_o, req_ready_o}, 2'b10);
    rport(1'b1, 1'b1, 1'b1, 11'h000, 8'h00);
    wait_done();
    check(dev_u.mem[11'h123], 8'h77);
    acc(1'b0, 11'h123, 8'h00);
    check({rdata_o, contention_err_o}, {8'h77, 1'b0});
  endtask
  // right port arrives later on the same byte: it loses, the left write lands
  task automatic t_late_right();
    start(1'b1, 11'h0f0, 8'h4b);
    repeat (2) @(negedge sys_clk_i);
    rport(1'b0, 1'b0, 1'b1, 11'h0f0, 8'hb4);
    wait_done();
    check({dev_u.mem[11'h0f0], contention_err_o}, {8'h4b, 1'b0});
    rport(1'b1, 1'b1, 1'b1, 11'h000, 8'h00);
    check(dev_u.mem[11'h0f0], 8'hb4);
  endtask
  // outside busy pulled low in mid write pulse: strobe dropped, write retried
  task automatic t_slave_busy();
    start(1'b1, 11'h3a5, 8'h69);
    repeat (2) @(negedge sys_clk_i);
    hold_n = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    check({contention_err_o, ram_rw_n_o, req_ready_o}, 3'b110);
    check(dev_u.mem[11'h3a5], 8'hff);
    hold_n = 1'b1;
    wait_done();
    check(dev_u.mem[11'h3a5], 8'h69);
  endtask
  // reset in the middle of a write pulse: pins go idle, next access works
  task automatic t_mid_reset();
    start(1'b1, 11'h055, 8'h3e);
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    t_reset();
    acc(1'b1, 11'h055, 8'hc3);
    check(dev_u.mem[11'h055], 8'hc3);
  endtask
  initial begin
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_rw();
    t_mail_out();
    t_mail_in();
    t_wr_block();
    t_late_right();
    t_slave_busy();
    t_mid_reset();
    stop_test();
  end
endmodule
`default_nettype wire
